// ---- logic/sswd_pkg.sv ----
/*
 * Constants and types shared by the supply supervisor and watchdog.
 * Assumes a 100 MHz system clock and an external comparator that
 * supplies the supply-level flags.
 */
// Overview of operation
// - Hold reset one full interval after threshold
// - Hold interval scales 3.125 ms per unit
// - Reset low above 1 V until sequence completes
// - Filtered short glitches leave reset high
// - Unfiltered glitch asserts reset one full interval
// - After glitch interval, release if above threshold
// - Assert reset below threshold minus hysteresis
// - Kick window scales 25 ms per unit
// - Expiry drops alarm until kick or reset
// - Reset forces alarm high, restarts window
// - Every kick restarts the window from zero
// - Reset and alarm outputs kept separate, merging left to board
package sswd_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam real CLK_MHZ = 100.0;
    localparam real HOLD_MS_PER_UNIT = 3.125;
    localparam real KICK_MS_PER_UNIT = 25.0;
    localparam real GLITCH_FILTER_US = 120.0;
    localparam int unsigned HOLD_CYC_PER_UNIT = int'(HOLD_MS_PER_UNIT * 1000.0 * CLK_MHZ);
    localparam int unsigned KICK_CYC_PER_UNIT = int'(KICK_MS_PER_UNIT * 1000.0 * CLK_MHZ);
    localparam int unsigned GLITCH_FILTER_CYC = int'(GLITCH_FILTER_US * CLK_MHZ);

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int CNT_W = 32;
    localparam int FILT_W = 16;
    localparam int SET_W = 8;
    localparam logic HOLD_N_RST = 1'b0;
    localparam logic ALARM_N_RST = 1'b1;

    // ----------------------------------------
    // Supervisor states
    // ----------------------------------------
    typedef enum logic [3:0] {
        SSWD_OFF = 4'h1,
        SSWD_ARM = 4'h2,
        SSWD_HOLD = 4'h4,
        SSWD_RUN = 4'h8
    } sswd_state_t;

endpackage

// ---- logic/sswd_glitch_filter.sv ----
/*
 * Threshold-sense glitch filter.
 * Assumes the raw low flag is synchronous to i_clk.
 */
`timescale 1ns/100ps
module sswd_glitch_filter
    import sswd_pkg::*;
#(
    parameter logic [FILT_W-1:0] FILTER_CYC = FILT_W'(GLITCH_FILTER_CYC)
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sys_reset,
    input wire logic i_raw_low,
    output logic o_low_confirmed
);

    typedef struct packed {
        logic [FILT_W-1:0] cnt;
        logic low;
    } sswd_filt_t;

    sswd_filt_t s;
    sswd_filt_t next_s;

    // Low must persist FILTER_CYC cycles in a row to count
    always_comb begin
        next_s = s;
        next_s.low = 1'b0;
        if (i_sys_reset || !i_raw_low) begin
            next_s.cnt = '0;
        end else if (s.cnt >= FILTER_CYC - FILT_W'(1)) begin
            next_s.low = 1'b1;
        end else begin
            next_s.cnt = s.cnt + FILT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_low_confirmed = s.low;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_short_absorbed: assert property (!i_raw_low |=> !o_low_confirmed)
        else $error("Filter passed a released low");

endmodule

// ---- logic/sswd_supervisor.sv ----
/*
 * Supply supervisor with watchdog: active-low hold output and alarm.
 * Assumes comparator flags and kick input arrive as plain levels;
 * the kick input may be asynchronous and is synchronised here.
 */
`timescale 1ns/100ps
module sswd_supervisor
    import sswd_pkg::*;
#(
    parameter int unsigned HOLD_CYC_UNIT = HOLD_CYC_PER_UNIT,
    parameter int unsigned KICK_CYC_UNIT = KICK_CYC_PER_UNIT,
    parameter logic [FILT_W-1:0] FILTER_CYC = FILT_W'(GLITCH_FILTER_CYC)
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sys_reset,
    input wire logic i_supply_valid,
    input wire logic i_threshold_sense,
    input wire logic i_below_hysteresis,
    input wire logic [SET_W-1:0] i_hold_timing_setting,
    input wire logic [SET_W-1:0] i_kick_window_setting,
    input wire logic i_kick_input,
    output logic o_supervisor_hold_n,
    output logic o_timeout_alarm_n
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sswd_state_t st;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] kick_cnt;
        logic kick_meta;
        logic kick_sync;
        logic kick_prev;
        logic hold_n;
        logic alarm_n;
    } sswd_regs_t;

    sswd_regs_t s;
    sswd_regs_t next_s;
    logic low_confirmed;
    logic kick_edge;
    logic [CNT_W-1:0] hold_load;
    logic [CNT_W-1:0] kick_load;

    // ----------------------------------------
    // Interval lengths
    // ----------------------------------------
    // Linear in the setting; zero setting gives an immediate expiry
    assign hold_load = CNT_W'(i_hold_timing_setting) * CNT_W'(HOLD_CYC_UNIT);
    assign kick_load = CNT_W'(i_kick_window_setting) * CNT_W'(KICK_CYC_UNIT);

    // Depth is judged by the hysteresis flag, duration by the filter
    sswd_glitch_filter #(
        .FILTER_CYC(FILTER_CYC)
    ) u_filter (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sys_reset(i_sys_reset),
        .i_raw_low(i_below_hysteresis),
        .o_low_confirmed(low_confirmed)
    );

    // Second and third stages are compared; first stage feeds nothing else
    assign kick_edge = s.kick_sync ^ s.kick_prev;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.kick_meta = i_kick_input;
        next_s.kick_sync = s.kick_meta;
        next_s.kick_prev = s.kick_sync;

        // Supervisor sequence
        if (i_sys_reset) begin
            next_s.st = SSWD_ARM;
            next_s.hold_cnt = hold_load;
        end else if (!i_supply_valid) begin
            next_s.st = SSWD_OFF;
            next_s.hold_cnt = hold_load;
        end else begin
            case (s.st)
                SSWD_OFF: begin
                    next_s.st = SSWD_ARM;
                end
                SSWD_ARM: begin
                    next_s.hold_cnt = hold_load;
                    if (i_threshold_sense) begin
                        next_s.st = SSWD_HOLD;
                    end
                end
                SSWD_HOLD: begin
                    // Full interval even if the supply dips again
                    if (s.hold_cnt == '0) begin
                        next_s.st = i_threshold_sense ? SSWD_RUN : SSWD_ARM;
                    end else begin
                        next_s.hold_cnt = s.hold_cnt - CNT_W'(1);
                    end
                end
                SSWD_RUN: begin
                    if (low_confirmed) begin
                        next_s.st = SSWD_HOLD;
                        next_s.hold_cnt = hold_load;
                    end
                end
                default: begin
                    next_s.st = SSWD_ARM;
                    next_s.hold_cnt = hold_load;
                end
            endcase
        end
        next_s.hold_n = (next_s.st == SSWD_RUN);

        // Watchdog: only its own inputs and the hold output steer it
        if (!next_s.hold_n) begin
            next_s.alarm_n = 1'b1;
            next_s.kick_cnt = kick_load;
        end else if (kick_edge) begin
            next_s.alarm_n = 1'b1;
            next_s.kick_cnt = kick_load;
        end else if (s.kick_cnt == '0) begin
            next_s.alarm_n = 1'b0;
        end else begin
            next_s.kick_cnt = s.kick_cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s.st <= SSWD_OFF;
            s.hold_cnt <= '0;
            s.kick_cnt <= '0;
            s.kick_meta <= 1'b0;
            s.kick_sync <= 1'b0;
            s.kick_prev <= 1'b0;
            s.hold_n <= HOLD_N_RST;
            s.alarm_n <= ALARM_N_RST;
        end else begin
            s <= next_s;
        end
    end

    // Either output low means a fault; merging is left to the board
    assign o_supervisor_hold_n = s.hold_n;
    assign o_timeout_alarm_n = s.alarm_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_hold_full_interval: assert property (
        $rose(o_supervisor_hold_n) |-> $past(s.st) == SSWD_HOLD && $past(s.hold_cnt) == '0)
        else $error("Hold released before interval end");

    a_low_until_run: assert property (
        s.st != SSWD_RUN |-> !o_supervisor_hold_n)
        else $error("Hold output high outside run");

    a_glitch_absorbed: assert property (
        (s.st == SSWD_RUN && !low_confirmed && i_supply_valid && !i_sys_reset)
        |=> o_supervisor_hold_n)
        else $error("Absorbed glitch dropped hold output");

    a_glitch_full_hold: assert property (
        (s.st == SSWD_RUN && low_confirmed && i_supply_valid && !i_sys_reset)
        |=> s.st == SSWD_HOLD && !o_supervisor_hold_n && s.hold_cnt == $past(hold_load))
        else $error("Deep glitch did not start a hold interval");

    a_release_after_hold: assert property (
        (s.st == SSWD_HOLD && s.hold_cnt == '0 && i_threshold_sense
        && i_supply_valid && !i_sys_reset) |=> o_supervisor_hold_n)
        else $error("Hold not released at interval end");

    a_alarm_on_expiry: assert property (
        (s.kick_cnt == '0 && !kick_edge && next_s.hold_n) |=> !o_timeout_alarm_n)
        else $error("Alarm not raised at window expiry");

    a_alarm_stays_low: assert property (
        (!o_timeout_alarm_n && !kick_edge && next_s.hold_n) |=> !o_timeout_alarm_n)
        else $error("Alarm released without kick or reset");

    a_alarm_high_reset: assert property (
        !o_supervisor_hold_n |-> o_timeout_alarm_n)
        else $error("Alarm not forced high during reset");

    // Counter is zero straight out of the async reset, so skip that cycle
    a_window_held_reset: assert property (
        ($past(i_reset_n) && !o_supervisor_hold_n) |-> s.kick_cnt == $past(kick_load))
        else $error("Window not held full during reset");

    a_hold_low_supply: assert property (
        (!i_supply_valid && !i_sys_reset) |=> s.st == SSWD_OFF && !o_supervisor_hold_n)
        else $error("Hold output high with supply invalid");

    a_arm_waits: assert property (
        (s.st == SSWD_ARM && !i_threshold_sense && i_supply_valid && !i_sys_reset)
        |=> s.st == SSWD_ARM && !o_supervisor_hold_n)
        else $error("Hold sequence began below threshold");

    a_hold_countdown: assert property (
        (s.st == SSWD_HOLD && s.hold_cnt != '0 && i_supply_valid && !i_sys_reset)
        |=> s.st == SSWD_HOLD && s.hold_cnt == $past(s.hold_cnt) - CNT_W'(1))
        else $error("Hold interval did not count down");

    a_window_countdown: assert property (
        (next_s.hold_n && !kick_edge && s.kick_cnt != '0)
        |=> s.kick_cnt == $past(s.kick_cnt) - CNT_W'(1))
        else $error("Kick window did not count down");

    // Pin is seen two samples late; the first cycles after reset see flop zeros
    a_kick_two_stage: assert property (
        (kick_edge && $past(i_reset_n, 3))
        |-> $past(i_kick_input, 2) != $past(i_kick_input, 3))
        else $error("Kick edge not from the synchronised pin");

    a_kick_restart: assert property (
        (kick_edge && next_s.hold_n) |=> o_timeout_alarm_n && s.kick_cnt == $past(kick_load))
        else $error("Kick did not restart the window");

    a_sys_reset_init: assert property (
        i_sys_reset |=> !o_supervisor_hold_n && o_timeout_alarm_n
        && s.hold_cnt == $past(hold_load))
        else $error("System reset did not initialise outputs");

endmodule

// ---- tb/sswd_cpu_model.sv ----
/*
 * Processor model: flips the kick line once every i_gap cycles while running,
 * and merges the two fault outputs into its own reset line.
 * Assumes i_gap >= 1 and controls that change just after rising edges.
 */
`timescale 1ns/100ps
module sswd_cpu_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_gap,
    input wire logic i_hold_n,
    input wire logic i_alarm_n,
    output logic o_kick_input,
    output logic o_merged_reset_n
);
    logic [7:0] cnt;

    // Either fault output resets the processor
    assign o_merged_reset_n = i_hold_n & i_alarm_n;

    initial begin
        o_kick_input = 1'b0;
        cnt = 8'h00;
    end

    // Either edge counts, so one flip is one kick
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= i_gap) begin
            cnt <= 8'h00;
            o_kick_input <= ~o_kick_input;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// ---- tb/supply_supervisor_watchdog_tb.sv ----
/*
 * Self-checking bench for the supervisor and watchdog.
 * Assumes short test counts on the top parameters and a processor model.
 */
`timescale 1ns/100ps
module supply_supervisor_watchdog_tb;
    import sswd_pkg::*;
    localparam int HU = 4;
    localparam int KU = 8;
    localparam int N = 2 * HU;
    localparam int W = 2 * KU;
    localparam int LIMIT = 20 * (N + W) + 2000;
    typedef struct {logic [1:0] val; int early;} sswd_note_t;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_sys_reset = 1'b0;
    logic i_supply_valid = 1'b1;
    logic i_threshold_sense = 1'b1;
    logic i_below_hysteresis = 1'b0;
    logic run = 1'b1;
    logic [7:0] gap = 8'h04;
    logic [7:0] hold_set = 8'h02;
    logic [7:0] kick_set = 8'h02;
    logic merged;
    logic kick;
    logic o_supervisor_hold_n;
    logic o_timeout_alarm_n;
    logic [1:0] prev = 2'b01;
    logic [31:0] lfsr = 32'h086c;
    int cyc = 0;
    int n_fail = 0;
    int n_tests = 0;
    sswd_note_t notes[$];
    sswd_note_t nt;

    always #5 i_clk = ~i_clk;

    sswd_cpu_model partner (
        .i_clk(i_clk),
        .i_run(run),
        .i_gap(gap),
        .i_hold_n(o_supervisor_hold_n),
        .i_alarm_n(o_timeout_alarm_n),
        .o_kick_input(kick),
        .o_merged_reset_n(merged)
    );

    sswd_supervisor #(.HOLD_CYC_UNIT(HU), .KICK_CYC_UNIT(KU), .FILTER_CYC(16'h0003)) uut (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_sys_reset(i_sys_reset),
        .i_supply_valid(i_supply_valid),
        .i_threshold_sense(i_threshold_sense),
        .i_below_hysteresis(i_below_hysteresis),
        .i_hold_timing_setting(hold_set),
        .i_kick_window_setting(kick_set),
        .i_kick_input(kick),
        .o_supervisor_hold_n(o_supervisor_hold_n),
        .o_timeout_alarm_n(o_timeout_alarm_n)
    );

    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic bad(input string m);
        n_fail++;
        $display("BAD %0t %s", $time, m);
    endtask

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (!i_reset_n) begin
            prev <= 2'b01;
        end else if ({o_supervisor_hold_n, o_timeout_alarm_n} !== prev) begin
            prev <= {o_supervisor_hold_n, o_timeout_alarm_n};
            n_tests++;
            if (notes.size() == 0) begin
                bad("unexpected output change");
            end else begin
                nt = notes.pop_front();
                if (nt.val !== {o_supervisor_hold_n, o_timeout_alarm_n} || cyc < nt.early) begin
                    bad("wrong output value or too early");
                end
            end
        end
    end

    // Note a change, then give it a bounded time to show up
    task automatic expect_out(input logic [1:0] v, input int lo, input int hi);
        int k;
        notes.push_back('{v, cyc + lo});
        k = 0;
        while (notes.size() != 0 && k < hi) begin
            @(posedge i_clk);
            k++;
        end
        if (notes.size() != 0) begin
            bad("output change missing");
            notes.delete();
        end
    endtask

    task automatic steady(input logic [1:0] v);
        n_tests++;
        if ({o_supervisor_hold_n, o_timeout_alarm_n} !== v) begin
            bad("outputs not as expected");
        end
        if (merged !== &v) begin
            bad("merged reset not low on a fault");
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        idle(20);
        i_reset_n <= 1'b1;
        steady(2'b01);
        expect_out(2'b11, N, N + 6);
        $display("test power-up done");
        for (int i = 0; i < 8; i++) begin
            lfsr = next_lfsr(lfsr);
            gap <= 8'h02 + {5'h00, lfsr[2:0]};
            i_below_hysteresis <= 1'b1;
            idle(1 + int'(lfsr[3]));
            i_below_hysteresis <= 1'b0;
            idle(6);
        end
        steady(2'b11);
        $display("test short glitches done");
        run <= 1'b0;
        expect_out(2'b10, W - 4, W + 6);
        idle(5);
        steady(2'b10);
        run <= 1'b1;
        expect_out(2'b11, 3, int'(gap) + 6);
        $display("test kick window done");
        i_below_hysteresis <= 1'b1;
        expect_out(2'b01, 3, 8);
        i_below_hysteresis <= 1'b0;
        run <= 1'b0;
        steady(2'b01);
        expect_out(2'b11, N - 2, N + 4);
        expect_out(2'b10, W - 2, W + 4);
        run <= 1'b1;
        expect_out(2'b11, 3, int'(gap) + 6);
        $display("test long glitch done");
        i_supply_valid <= 1'b0;
        i_threshold_sense <= 1'b0;
        expect_out(2'b01, 1, 3);
        i_supply_valid <= 1'b1;
        idle(N + 6);
        steady(2'b01);
        i_threshold_sense <= 1'b1;
        expect_out(2'b11, N, N + 6);
        $display("test supply drop done");
        i_sys_reset <= 1'b1;
        hold_set <= 8'h03;
        kick_set <= 8'h01;
        gap <= 8'h03;
        run <= 1'b0;
        idle(1);
        i_sys_reset <= 1'b0;
        expect_out(2'b01, 0, 3);
        expect_out(2'b11, 3 * HU, 3 * HU + 6);
        expect_out(2'b10, KU - 2, KU + 4);
        run <= 1'b1;
        expect_out(2'b11, 3, int'(gap) + 6);
        $display("test system reset done");
        conclude();
    end

    initial begin
        idle(LIMIT);
        bad("run did not finish in time");
        conclude();
    end
endmodule
